// ---- crank_pickup_params.svh ----
// constants of the crank pickup conditioner: field positions, reset values, timing
// assumes inclusion by bare name from the design files
`ifndef CRANK_PICKUP_PARAMS_SVH
`define CRANK_PICKUP_PARAMS_SVH

// field positions inside a manual parameter set
`define CPC_THR_MSB 7
`define CPC_THR_LSB 4
`define CPC_BLK_MSB 3
`define CPC_BLK_LSB 0

// reset values, and the all-zero cranking set value that selects the running set
`define CPC_PARAM_RESET 8'h50
`define CPC_THR_DEFAULT 4'h5
`define CPC_BLK_DEFAULT 4'h0
`define CPC_CRANK_ZERO 8'h00

// highest comparator threshold code, used on a zero crossing in automatic mode
`define CPC_THR_MAX 4'hF

// blanking step is 1/32 of the reference pulse per code step
`define CPC_BLANK_SHIFT 5

// decay interval per threshold step is (mantissa + base) shifted by exponent, plus one, clock cycles
`define CPC_MANT_BASE 12'h010
`define CPC_DECAY_W 12

`endif

// ---- crank_pickup_pkg.sv ----
// types shared by the crank pickup conditioner files
// assumes nothing beyond a SystemVerilog compiler
package crank_pickup_pkg;

  // one manual parameter set: threshold code high nibble, blanking code low nibble
  typedef logic [7:0] param_t;

  // state of the automatic threshold decay
  typedef enum logic [0:0] {DECAY_IDLE, DECAY_RUN} decay_state_e;

endpackage

// ---- tach_pulse_divider.sv ----
// divider of the conditioned pulse toward the tachometer output
// assumes pulse_in is already synchronous to clk
`timescale 1ns/100ps

module tach_pulse_divider #(
  parameter int DIV_W = 4 // width of the ratio field
) (
  input wire logic clk, // system clock
  input wire logic nrst_n, // synchronous reset, active low
  input wire logic pulse_in, // conditioned pulse
  input wire logic div_en, // divide when high, pass through when low
  input wire logic [DIV_W-1:0] div_ratio, // output toggles every div_ratio+1 rising edges
  output logic pulse_out // tachometer pulse, from a flop
);

  logic prev_q;
  logic prev_d;
  logic out_q;
  logic out_d;
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;

  if (DIV_W < 1)
  begin : g_bad_width
    $error("tach_pulse_divider: DIV_W must be at least 1");
  end

  // next state of the divider
  always_comb
  begin
    prev_d = pulse_in;
    out_d = out_q;
    cnt_d = cnt_q;
    if (!div_en)
    begin
      out_d = pulse_in;
      cnt_d = '0;
    end
    else if (pulse_in && !prev_q)
    begin
      if (cnt_q == div_ratio)
      begin
        cnt_d = '0;
        out_d = ~out_q;
      end
      else
      begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // divider registers
  always_ff @(posedge clk)
  begin
    if (!nrst_n)
    begin
      prev_q <= 1'b0;
      out_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      prev_q <= prev_d;
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end

  assign pulse_out = out_q;

  property p_div_bypass;
    @(posedge clk) disable iff (!nrst_n)
    !div_en ##1 !div_en |-> pulse_out == $past(pulse_in);
  endproperty
  a_div_bypass: assert property (p_div_bypass) else $error("tach output does not follow pulse in bypass");

endmodule

// ---- crank_pickup_conditioner.sv ----
// digital control of the crank wheel pickup conditioner: parameter set choice,
// automatic threshold decay, one-shot blanking and tachometer division
// assumes the analog comparators sit outside and their outputs arrive asynchronously
// Functional notes
// - the conditioned pulse output carries the digitised tooth wheel signal as an angle clock.
// - the pickup may be differential or single-ended, the latter grounding the negative input.
// - the comparator threshold is a 4-bit code from the parameter set in effect.
// - the threshold code is the upper nibble of both the cranking and running sets.
// - codes map to sixteen rising levels up to the top one, and the code after reset is 0101.
// - two parameter sets, cranking and running, each hold a threshold and a blanking code.
// - an all-zero cranking set makes the running set take effect.
// - a nonzero cranking set supplies both threshold and blanking.
// - a one-shot blanking stage holds the output still while it is active.
// - blanking length is a percentage of the last high pulse, or the low one when selected.
// - the conditioned pulse may be divided onto the tachometer output.
// - the threshold may instead be adjusted automatically from the signal amplitude.
// - the blanking code in the low nibble gives zero at 0000 and 3.125 percent per step.
// - in automatic mode each zero crossing jumps to the top threshold, then decays at a set rate.
`timescale 1ns/100ps
`include "crank_pickup_params.svh"

module crank_pickup_conditioner #(
  parameter int CNT_W = 16, // width of the pulse-width and blanking counters
  parameter int DIV_W = 4 // width of the tachometer ratio
) (
  input wire logic MCLK, // 20 MHz clock
  input wire logic NRST, // synchronous reset, active low
  input wire logic PICKUP_CMP, // threshold comparator of pickup_in_pos against pickup_in_neg, async
  input wire logic PICKUP_ZERO, // zero-crossing comparator of the pickup, async
  input wire logic [7:0] RUN_PARAM, // running set: threshold and blanking codes
  input wire logic [7:0] CRANK_PARAM, // cranking set, all zero means unused
  input wire logic AUTO_MODE, // automatic threshold decay enable
  input wire logic [3:0] DECAY_MANT, // decay mantissa
  input wire logic [2:0] DECAY_EXP, // decay exponent
  input wire logic REF_LOW_SEL, // measure low pulse instead of high pulse
  input wire logic SINGLE_ENDED_SEL, // single-ended sensor connection
  input wire logic TACH_DIV_EN, // divide toward the tachometer output
  input wire logic [DIV_W-1:0] TACH_DIV_RATIO, // tachometer ratio
  output logic [3:0] THRESH_CODE, // code to the threshold converter
  output logic NEG_GND_EN, // grounds the negative pickup input
  output logic CRANK_SET_ACTIVE, // cranking set in effect
  output logic BLANK_ACTIVE, // one-shot blanking running
  output logic CONDITIONED_PULSE_OUT, // conditioned_pulse_out to the host
  output logic TACH_PULSE_OUT // tach_pulse_out
);

  // ****************************************************************
  // declarations and decode
  // ****************************************************************
  logic cmp_m_q, cmp_s_q, zc_m_q, zc_s_q, zc_p_q;
  logic zc_evt;
  crank_pickup_pkg::param_t sel_q, sel_d;
  logic crank_q, crank_d, neg_q, neg_d;
  logic [3:0] sel_thr, run_thr, crank_thr;
  crank_pickup_pkg::decay_state_e decay_st_q, decay_st_d;
  logic [3:0] auto_thr_q, auto_thr_d, thr_q, thr_d;
  logic [`CPC_DECAY_W-1:0] decay_cnt_q, decay_cnt_d, decay_len;
  logic out_q, out_d, blank_act_q, blank_act_d, ref_lvl;
  logic [CNT_W-1:0] blank_cnt_q, blank_cnt_d, run_cnt_q, run_cnt_d;
  logic [CNT_W-1:0] width_q, width_d, blank_len_q, blank_len_d;
  logic [CNT_W+3:0] prod;

  if (CNT_W < 6 || CNT_W > 30)
  begin : g_bad_cnt
    $error("crank_pickup_conditioner: CNT_W must lie in 6..30");
  end

  // threshold code field of a parameter set
  // threshold in upper nibble
  function automatic logic [3:0] thr_of(input crank_pickup_pkg::param_t p);
    thr_of = p[`CPC_THR_MSB:`CPC_THR_LSB];
  endfunction

  // blanking code field of a parameter set
  function automatic logic [3:0] blk_of(input crank_pickup_pkg::param_t p);
    blk_of = p[`CPC_BLK_MSB:`CPC_BLK_LSB];
  endfunction

  assign sel_thr = thr_of(sel_q);
  assign run_thr = thr_of(RUN_PARAM);
  assign crank_thr = thr_of(CRANK_PARAM);
  assign zc_evt = zc_s_q & ~zc_p_q;
  assign decay_len = (`CPC_MANT_BASE + {8'h00, DECAY_MANT}) << DECAY_EXP;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // two flops per async comparator, edge detect on the second stage only
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      cmp_m_q <= 1'b0;
      cmp_s_q <= 1'b0;
      zc_m_q <= 1'b0;
      zc_s_q <= 1'b0;
      zc_p_q <= 1'b0;
    end
    else
    begin
      cmp_m_q <= PICKUP_CMP;
      cmp_s_q <= cmp_m_q;
      zc_m_q <= PICKUP_ZERO;
      zc_s_q <= zc_m_q;
      zc_p_q <= zc_s_q;
    end
  end

  // ****************************************************************
  // parameter set selection and threshold
  // ****************************************************************
  // choice of set, automatic decay and the threshold code
  always_comb
  begin
    // zero cranking set selects running set
    crank_d = (CRANK_PARAM != `CPC_CRANK_ZERO);
    sel_d = crank_d ? CRANK_PARAM : RUN_PARAM;
    neg_d = SINGLE_ENDED_SEL;
    auto_thr_d = auto_thr_q;
    decay_cnt_d = decay_cnt_q;
    decay_st_d = decay_st_q;
    if (!AUTO_MODE)
    begin
      decay_st_d = crank_pickup_pkg::DECAY_IDLE;
      auto_thr_d = sel_thr;
    end
    else if (zc_evt)
    begin
      decay_st_d = crank_pickup_pkg::DECAY_RUN;
      auto_thr_d = `CPC_THR_MAX;
      decay_cnt_d = decay_len;
    end
    else
    begin
      unique case (decay_st_q)
        crank_pickup_pkg::DECAY_IDLE:
        begin
          auto_thr_d = sel_thr;
        end
        crank_pickup_pkg::DECAY_RUN:
        begin
          if (auto_thr_q <= sel_thr)
          begin
            auto_thr_d = sel_thr;
            decay_st_d = crank_pickup_pkg::DECAY_IDLE;
          end
          else if (decay_cnt_q == '0)
          begin
            auto_thr_d = auto_thr_q - 4'h1;
            decay_cnt_d = decay_len;
          end
          else
          begin
            decay_cnt_d = decay_cnt_q - 1'b1;
          end
        end
      endcase
    end
    thr_d = AUTO_MODE ? auto_thr_q : sel_thr;
  end

  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      sel_q <= `CPC_PARAM_RESET;
      crank_q <= 1'b0;
      neg_q <= 1'b0;
      decay_st_q <= crank_pickup_pkg::DECAY_IDLE;
      auto_thr_q <= `CPC_THR_DEFAULT;
      decay_cnt_q <= '0;
      thr_q <= `CPC_THR_DEFAULT;
    end
    else
    begin
      sel_q <= sel_d;
      crank_q <= crank_d;
      neg_q <= neg_d;
      decay_st_q <= decay_st_d;
      auto_thr_q <= auto_thr_d;
      decay_cnt_q <= decay_cnt_d;
      thr_q <= thr_d;
    end
  end

  // ****************************************************************
  // pulse measurement and one-shot blanking
  // ****************************************************************
  // output follows the comparator outside blanking; widths feed the next blanking time
  always_comb
  begin
    ref_lvl = ~REF_LOW_SEL;
    out_d = out_q;
    blank_cnt_d = blank_cnt_q;
    if (blank_cnt_q != '0)
    begin
      blank_cnt_d = blank_cnt_q - 1'b1;
    end
    else if (cmp_s_q != out_q)
    begin
      out_d = cmp_s_q;
      blank_cnt_d = blank_len_q;
    end
    blank_act_d = (blank_cnt_d != '0);
    // width of high or low reference pulse
    // count reference pulse in clock cycles
    run_cnt_d = '0;
    if (out_q == ref_lvl)
    begin
      run_cnt_d = (run_cnt_q == '1) ? run_cnt_q : run_cnt_q + 1'b1;
    end
    width_d = width_q;
    if (out_q == ref_lvl && out_d != ref_lvl)
    begin
      // take the count with this last reference cycle included
      width_d = run_cnt_d;
    end
    // blanking code from the set in effect
    prod = {4'h0, width_q} * {{CNT_W{1'b0}}, blk_of(sel_q)};
    blank_len_d = {1'b0, prod[CNT_W+3:`CPC_BLANK_SHIFT]};
  end

  // pulse registers
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      out_q <= 1'b0;
      blank_cnt_q <= '0;
      blank_act_q <= 1'b0;
      run_cnt_q <= '0;
      width_q <= '0;
      blank_len_q <= '0;
    end
    else
    begin
      out_q <= out_d;
      blank_cnt_q <= blank_cnt_d;
      blank_act_q <= blank_act_d;
      run_cnt_q <= run_cnt_d;
      width_q <= width_d;
      blank_len_q <= blank_len_d;
    end
  end

  // ****************************************************************
  // tachometer divider and outputs
  // ****************************************************************
  // divided pulse toward tachometer
  tach_pulse_divider #(
    .DIV_W(DIV_W)
  ) u_tach (
    .clk(MCLK),
    .nrst_n(NRST),
    .pulse_in(out_q),
    .div_en(TACH_DIV_EN),
    .div_ratio(TACH_DIV_RATIO),
    .pulse_out(TACH_PULSE_OUT)
  );

  // outputs straight from flops
  assign THRESH_CODE = thr_q;
  assign NEG_GND_EN = neg_q;
  assign CRANK_SET_ACTIVE = crank_q;
  assign BLANK_ACTIVE = blank_act_q;
  assign CONDITIONED_PULSE_OUT = out_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  sequence s_manual_run;
    !AUTO_MODE ##0 $past(CRANK_PARAM) == `CPC_CRANK_ZERO;
  endsequence
  sequence s_zc_auto;
    (zc_evt && AUTO_MODE) ##1 AUTO_MODE;
  endsequence
  sequence s_free_edge;
    blank_cnt_q == '0 && cmp_s_q != out_q;
  endsequence

  property p_run_set;
    s_manual_run |=> THRESH_CODE == $past(run_thr, 2);
  endproperty
  a_run_set: assert property (p_run_set) else $error("running set not applied");

  property p_crank_set;
    !AUTO_MODE && $past(CRANK_PARAM) != `CPC_CRANK_ZERO |-> CRANK_SET_ACTIVE ##1 THRESH_CODE == $past(crank_thr, 2);
  endproperty
  a_crank_set: assert property (p_crank_set) else $error("cranking set not applied");

  property p_thr_reset;
    $rose(NRST) |-> THRESH_CODE == `CPC_THR_DEFAULT;
  endproperty
  a_thr_reset: assert property (p_thr_reset) else $error("threshold code wrong after reset");

  property p_blank_hold;
    blank_cnt_q != '0 |=> $stable(CONDITIONED_PULSE_OUT);
  endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("output moved during blanking");

  property p_blank_load;
    $changed(CONDITIONED_PULSE_OUT) |-> blank_cnt_q == $past(blank_len_q) && BLANK_ACTIVE == (blank_cnt_q != '0);
  endproperty
  a_blank_load: assert property (p_blank_load) else $error("blanking not started on output edge");

  property p_follow;
    s_free_edge |=> CONDITIONED_PULSE_OUT == $past(cmp_s_q);
  endproperty
  a_follow: assert property (p_follow) else $error("output missed a comparator edge");

  property p_zc_max;
    s_zc_auto |=> THRESH_CODE == `CPC_THR_MAX;
  endproperty
  a_zc_max: assert property (p_zc_max) else $error("zero crossing did not raise threshold");

  property p_decay_step;
    auto_thr_q < $past(auto_thr_q) |-> auto_thr_q == $past(auto_thr_q) - 4'h1 || auto_thr_q == $past(sel_thr);
  endproperty
  a_decay_step: assert property (p_decay_step) else $error("threshold decay skipped a step");

  property p_width;
    $past(out_q) == ~REF_LOW_SEL && out_q == REF_LOW_SEL && $stable(REF_LOW_SEL) |-> width_q == run_cnt_q && width_q != '0;
  endproperty
  a_width: assert property (p_width) else $error("reference width not captured");

endmodule

// ---- pickup_model.sv ----
// partner model: the pickup comparators as seen by the conditioner
// assumes a free-running MCLK from the bench
`timescale 1ns/100ps

module pickup_model (
  input wire logic MCLK, // system clock
  output logic PICKUP_CMP, // threshold comparator level
  output logic PICKUP_ZERO // zero-crossing comparator level
);
  // both comparators rest low until a tooth passes
  initial
  begin
    PICKUP_CMP = 1'b0;
    PICKUP_ZERO = 1'b0;
  end

  // one tooth: hi cycles above threshold, an optional 2-cycle dip, then lo cycles below
  task automatic tooth(input int hi, input int lo, input int dip);
    for (int i = 0; i < hi; i++)
    begin
      @(posedge MCLK);
      #5;
      PICKUP_ZERO = 1'b1;
      PICKUP_CMP = !(dip > 0 && i >= dip && i < dip + 2);
    end
    @(posedge MCLK);
    #5;
    PICKUP_CMP = 1'b0;
    PICKUP_ZERO = 1'b0;
    repeat (lo - 1) @(posedge MCLK);
  endtask
endmodule

// ---- crank_pickup_conditioner_test.sv ----
// self-checking bench of the crank pickup conditioner
// assumes pickup_model drives the comparator inputs
`timescale 1ns/100ps

module crank_pickup_conditioner_test;
  // ****************
  // signals
  // ****************
  logic MCLK = 1'b0;
  logic NRST = 1'b0;
  logic PICKUP_CMP;
  logic PICKUP_ZERO;
  logic [7:0] RUN_PARAM = 8'h50;
  logic [7:0] CRANK_PARAM = 8'h00;
  logic AUTO_MODE = 1'b0;
  logic [3:0] DECAY_MANT = 4'h0;
  logic [2:0] DECAY_EXP = 3'h0;
  logic REF_LOW_SEL = 1'b0;
  logic SINGLE_ENDED_SEL = 1'b0;
  logic TACH_DIV_EN = 1'b0;
  logic [3:0] TACH_DIV_RATIO = 4'h0;
  logic [3:0] THRESH_CODE;
  logic NEG_GND_EN;
  logic CRANK_SET_ACTIVE;
  logic BLANK_ACTIVE;
  logic CONDITIONED_PULSE_OUT;
  logic TACH_PULSE_OUT;
  int errors = 0;
  int checked = 0;

  // 20 MHz clock
  always #25 MCLK = ~MCLK;

  crank_pickup_conditioner #(.CNT_W(16), .DIV_W(4)) i_dut (
    .MCLK(MCLK), .NRST(NRST), .PICKUP_CMP(PICKUP_CMP), .PICKUP_ZERO(PICKUP_ZERO),
    .RUN_PARAM(RUN_PARAM), .CRANK_PARAM(CRANK_PARAM), .AUTO_MODE(AUTO_MODE),
    .DECAY_MANT(DECAY_MANT), .DECAY_EXP(DECAY_EXP), .REF_LOW_SEL(REF_LOW_SEL),
    .SINGLE_ENDED_SEL(SINGLE_ENDED_SEL), .TACH_DIV_EN(TACH_DIV_EN), .TACH_DIV_RATIO(TACH_DIV_RATIO),
    .THRESH_CODE(THRESH_CODE), .NEG_GND_EN(NEG_GND_EN), .CRANK_SET_ACTIVE(CRANK_SET_ACTIVE),
    .BLANK_ACTIVE(BLANK_ACTIVE), .CONDITIONED_PULSE_OUT(CONDITIONED_PULSE_OUT),
    .TACH_PULSE_OUT(TACH_PULSE_OUT)
  );

  pickup_model i_pick (.MCLK(MCLK), .PICKUP_CMP(PICKUP_CMP), .PICKUP_ZERO(PICKUP_ZERO));

  // ****************
  // helpers
  // ****************
  // verdict and end of run
  task automatic end_of_test;
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one comparison
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a wait that ran out of cycles
  task automatic timeout(input string what);
    errors++;
    $display("[ERR] %s expected event seen timeout", what);
    end_of_test;
  endtask

  // n edges, then settle before driving or sampling
  task automatic step(input int n);
    repeat (n) @(posedge MCLK);
    #5;
  endtask

  // ****************
  // scenarios
  // ****************
  // outputs during reset, then release of reset
  task automatic t_reset;
    step(5);
    check("thresh_rst", 16'h0005, THRESH_CODE);
    check("outs_rst", 16'h0000, {NEG_GND_EN, CRANK_SET_ACTIVE, BLANK_ACTIVE, CONDITIONED_PULSE_OUT, TACH_PULSE_OUT});
    NRST = 1'b1;
    step(3);
  endtask

  // every threshold code, then the cranking set over the running set
  task automatic t_select;
    for (int c = 1; c < 16; c++)
    begin
      RUN_PARAM = {4'(c), 4'h0};
      step(3);
      check("thresh_run", 16'(c), THRESH_CODE);
    end
    CRANK_PARAM = 8'h01;
    step(3);
    check("thresh_crank", 16'h0000, THRESH_CODE);
    check("crank_on", 16'h0001, CRANK_SET_ACTIVE);
    CRANK_PARAM = 8'hA0;
    step(3);
    check("thresh_crank_hi", 16'h000A, THRESH_CODE);
    CRANK_PARAM = 8'h00;
    step(3);
    check("thresh_back", 16'h000F, THRESH_CODE);
    check("crank_off", 16'h0000, CRANK_SET_ACTIVE);
  endtask

  // single-ended connection grounds the negative input
  task automatic t_single;
    SINGLE_ENDED_SEL = 1'b1;
    step(2);
    check("neg_gnd_on", 16'h0001, NEG_GND_EN);
    SINGLE_ENDED_SEL = 1'b0;
    step(2);
    check("neg_gnd_off", 16'h0000, NEG_GND_EN);
  endtask

  // blanking length after a rise, with a dip that it must hide, or must pass when the expected length is zero
  task automatic t_blank(input logic [7:0] crank, input logic ref_low, input int hi, input int lo, input int exp);
    int n;
    int blank;
    logic dropped;
    CRANK_PARAM = crank;
    REF_LOW_SEL = ref_low;
    step(2);
    i_pick.tooth(hi, lo, 0);
    i_pick.tooth(hi, lo, 0);
    fork
      i_pick.tooth(hi, lo, 1);
    join_none
    n = 0;
    blank = 0;
    dropped = 1'b0;
    while (CONDITIONED_PULSE_OUT !== 1'b1)
    begin
      step(1);
      n++;
      if (n > 10)
        timeout("pulse_rise");
    end
    for (int k = 0; k < 18; k++)
    begin
      if (BLANK_ACTIVE === 1'b1)
        blank++;
      if (CONDITIONED_PULSE_OUT !== 1'b1)
        dropped = 1'b1;
      step(1);
    end
    check("blank_len", 16'(exp), 16'(blank));
    check("blank_hold", {15'h0000, exp == 0}, {15'h0000, dropped});
    wait fork;
  endtask

  // jump to the top threshold on a zero crossing, then timed decay
  task automatic t_auto;
    int n;
    CRANK_PARAM = 8'h00;
    RUN_PARAM = 8'h40;
    DECAY_MANT = 4'h3;
    DECAY_EXP = 3'h1;
    AUTO_MODE = 1'b1;
    step(3);
    fork
      i_pick.tooth(4, 4, 0);
    join_none
    n = 0;
    while (THRESH_CODE !== 4'hF)
    begin
      step(1);
      n++;
      if (n > 12)
        timeout("thresh_top");
    end
    n = 0;
    while (THRESH_CODE !== 4'h4)
    begin
      step(1);
      n++;
      if (n > 600)
        timeout("thresh_decay");
    end
    // 11 steps of ((16+3)<<1)+1 cycles
    check("decay_time", 16'h0001, {15'h0000, n >= 423 && n <= 435});
    wait fork;
    // leave automatic mode while the threshold still sits at the top
    fork
      i_pick.tooth(4, 4, 0);
    join_none
    step(8);
    check("thresh_top", 16'h000F, THRESH_CODE);
    AUTO_MODE = 1'b0;
    step(3);
    check("thresh_manual", 16'h0004, THRESH_CODE);
    wait fork;
  endtask

  // pass-through, then divide by two and by four on the tachometer output
  task automatic t_tach;
    int bad;
    int rises;
    logic prev;
    step(2);
    fork
      repeat (3) i_pick.tooth(8, 8, 0);
    join_none
    bad = 0;
    rises = 0;
    prev = CONDITIONED_PULSE_OUT;
    for (int k = 0; k < 52; k++)
    begin
      step(1);
      if (TACH_PULSE_OUT !== prev)
        bad++;
      if (CONDITIONED_PULSE_OUT === 1'b1 && prev === 1'b0)
        rises++;
      prev = CONDITIONED_PULSE_OUT;
    end
    check("pulse_rises", 16'h0003, 16'(rises));
    check("tach_pass", 16'h0000, 16'(bad));
    wait fork;
    TACH_DIV_EN = 1'b1;
    // ratio 0 toggles on every rise, ratio 1 on every second rise
    for (int r = 0; r < 2; r++)
    begin
      TACH_DIV_RATIO = 4'(r);
      step(2);
      fork
        repeat (4) i_pick.tooth(8, 8, 0);
      join_none
      bad = 0;
      prev = TACH_PULSE_OUT;
      for (int k = 0; k < 70; k++)
      begin
        step(1);
        if (TACH_PULSE_OUT !== prev)
          bad++;
        prev = TACH_PULSE_OUT;
      end
      check("tach_div", 16'(4 / (r + 1)), 16'(bad));
      wait fork;
    end
  endtask

  // ****************
  // main sequence
  // ****************
  initial
  begin
    t_reset;
    t_select;
    t_single;
    t_blank(8'h28, 1'b0, 20, 40, 5);
    t_blank(8'h28, 1'b1, 20, 40, 10);
    t_blank(8'h2F, 1'b0, 32, 32, 15);
    t_blank(8'h20, 1'b0, 20, 20, 0);
    t_auto;
    t_tach;
    end_of_test;
  end
endmodule
